// [logic/core_regs_pkg.sv]
// package: register selectors, field layout, opcodes and states of the core
`default_nettype none
package core_regs_pkg;
  // register selectors used by the decoder
  localparam logic [4:0] SEL_HOST_CTRL = 5'h00;
  localparam logic [4:0] SEL_OUT_WORD = 5'h01;
  localparam logic [4:0] SEL_BD_DATA = 5'h02;
  localparam logic [4:0] SEL_DAC_OO = 5'h03;
  localparam logic [4:0] SEL_DAC_PO = 5'h04;
  localparam logic [4:0] SEL_DAC_OP = 5'h05;
  localparam logic [4:0] SEL_DAC_PP = 5'h06;
  localparam logic [4:0] SEL_DAC_SHARED = 5'h07;
  localparam logic [4:0] SEL_BD_ADDR = 5'h08;
  localparam logic [4:0] SEL_IRQ_MIRROR = 5'h09;
  localparam logic [4:0] SEL_EXCHANGE = 5'h0A;
  localparam logic [4:0] SEL_RAM_OFS = 5'h0B;
  localparam logic [4:0] SEL_GEN0 = 5'h10;
  localparam logic [4:0] SEL_MASK_SRC = 5'h15;
  localparam logic [4:0] SEL_PROD_HIGH = 5'h16;
  localparam logic [4:0] SEL_PROD_LOW = 5'h17;
  localparam logic [4:0] SEL_COND = 5'h18;
  // condition word bit positions
  localparam int B_SHIFT_OUT = 15;
  localparam int B_SIGN_ACC = 14;
  localparam int B_CARRY = 13;
  localparam int B_LIMIT_HI = 12;
  localparam int B_LIMIT_LO = 11;
  localparam int B_MASK_ZERO = 10;
  localparam int B_MASK_ONES = 9;
  localparam int B_PROD_HI_NZ = 8;
  localparam int B_PROD_LO_NZ = 7;
  localparam int B_SUM_ZERO = 6;
  localparam int B_SUM_NEG = 5;
  localparam int B_UNS_UNDER = 4;
  localparam int B_UNS_OVER = 3;
  localparam int B_SGN_UNDER = 2;
  localparam int B_SGN_OVER = 1;
  localparam int B_OP_DONE = 0;
  localparam logic [1:0] LIMIT_SIGNED = 2'h1;
  localparam logic [1:0] LIMIT_UNSIGNED = 2'h3;
  localparam logic [15:0] SAT_SMAX = 16'h7FFF;
  localparam logic [15:0] SAT_SMIN = 16'h8000;
  localparam logic [15:0] SAT_UMAX = 16'hFFFF;
  localparam logic [15:0] SAT_UMIN = 16'h0000;
  localparam logic [15:0] RESET_WORD = 16'h0000;
  localparam logic [4:0] MUL_CYCLES = 5'h10;
  localparam logic [5:0] RAM_ADDR_MASK = 6'h3F;
  typedef enum logic [3:0] {
    OP_NONE = 4'h0, OP_ADD = 4'h1, OP_SUB = 4'h2, OP_AND = 4'h3,
    OP_OR = 4'h4, OP_XOR = 4'h5, OP_NOT = 4'h6, OP_SHL = 4'h7,
    OP_SHR = 4'h8, OP_SHL32 = 4'h9, OP_SHR32 = 4'hA, OP_MUL = 4'hB,
    OP_TOINT = 4'hC, OP_TOINT_RST = 4'hD
  } alu_op_e;
  typedef enum logic [0:0] {ST_IDLE = 1'b0, ST_MUL = 1'b1} alu_state_e;
  typedef struct packed {
    alu_op_e op;
    logic [2:0] dst;
    logic [2:0] src_a;
    logic [2:0] src_b;
  } alu_req_s;
  typedef struct packed {
    logic wr;
    logic [4:0] sel;
    logic [15:0] data;
  } reg_wr_s;
endpackage
`default_nettype wire

// [logic/core_regs_alu.sv]
// core register set with ALU condition logic and DAC routing
`default_nettype none
module core_regs_alu
  import core_regs_pkg::*;
(
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic core_id_i,
  input wire logic channel_id_i,
  input wire logic split_status_i,
  input wire logic host_wr_i,
  input wire logic [15:0] host_wdata_i,
  input wire logic [15:0] core0_interrupt_flags_i,
  input wire logic [15:0] core1_interrupt_flags_i,
  input wire logic [15:0] exchange_in_i,
  input wire logic [1:0] exchange_route_i,
  input wire logic exchange_route_wr_i,
  input wire logic bit_set_i,
  input wire logic [2:0] bit_index_i,
  input wire logic bit_value_i,
  input wire logic [15:0] backdoor_rx_i,
  input wire logic backdoor_rx_valid_i,
  input wire logic ofs_wr_i,
  input wire logic [5:0] ofs_value_i,
  input wire logic [5:0] ram_addr_i,
  input wire logic ofs_sel_i,
  input wire reg_wr_s reg_wr_i,
  input wire logic [4:0] rd_sel_i,
  input wire logic alu_req_i,
  input wire alu_req_s alu_cmd_i,
  output logic [15:0] host_control_o,
  output logic [15:0] core_output_o,
  output logic [15:0] rd_data_o,
  output logic [15:0] backdoor_data_o,
  output logic [7:0] backdoor_address_o,
  output logic [13:0] current_dac_a_o,
  output logic [13:0] current_dac_b_o,
  output logic [13:0] current_dac_c_o,
  output logic [13:0] current_dac_d_o,
  output logic [11:0] shared_high_neg_dac_o,
  output logic [15:0] exchange_out_o,
  output logic [1:0] exchange_route_o,
  output logic [5:0] ram_addr_o,
  output logic [15:0] alu_condition_o
);
  logic [15:0] host_control_word_q;
  logic [15:0] core_output_word_q;
  logic [15:0] backdoor_data_q;
  logic [7:0] backdoor_address_q;
  logic [13:0] dac_rel_q [4];
  logic [11:0] shared_high_neg_dac_q;
  logic [15:0] interrupt_status_mirror_q;
  logic [15:0] core_exchange_word_q;
  logic [1:0] exchange_route_q;
  logic [5:0] data_ram_offset_q;
  logic [5:0] ram_addr_q;
  logic [15:0] gen_q [8];
  logic [15:0] cond_q;
  logic [15:0] rd_data_q;
  logic [13:0] dac_phys_q [4];
  alu_state_e state_q;
  logic [4:0] mul_cnt_q;
  logic [31:0] mul_acc_q;
  logic [15:0] mul_mcand_q;
  logic [15:0] mul_mplier_q;
  logic wr_en;
  logic alu_go;
  logic [15:0] op_a, op_b;
  logic [16:0] sum_ext;
  logic [15:0] sum_wrap, sum_out;
  logic sgn_over, sgn_under, uns_over, uns_under, carry;
  logic [15:0] mask_res;
  logic [31:0] pair, pair_sh;
  logic [15:0] one_sh;
  logic shift_bit;

  assign wr_en = reg_wr_i.wr;
  assign alu_go = alu_req_i && cond_q[B_OP_DONE];

  // physical index for relative slot j
  function automatic logic [1:0] dac_map(input logic core,
                                         input logic ch,
                                         input logic [1:0] j);
    dac_map = j ^ {ch, core};
  endfunction

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      host_control_word_q <= RESET_WORD;
    end else begin
      if (host_wr_i) begin
        host_control_word_q[7:0] <= host_wdata_i[7:0];
        if (!split_status_i) begin
          host_control_word_q[15:8] <= host_wdata_i[15:8];
        end
      end
      if (split_status_i && bit_set_i) begin
        host_control_word_q[{1'b1, bit_index_i}] <= bit_value_i;
      end
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      core_output_word_q <= RESET_WORD;
      backdoor_address_q <= 8'h00;
      shared_high_neg_dac_q <= 12'h000;
      data_ram_offset_q <= 6'h00;
      exchange_route_q <= 2'h0;
    end else begin
      if (wr_en && reg_wr_i.sel == SEL_OUT_WORD) begin
        core_output_word_q <= reg_wr_i.data;
      end
      if (wr_en && reg_wr_i.sel == SEL_BD_ADDR) begin
        backdoor_address_q <= reg_wr_i.data[7:0];
      end
      if (wr_en && reg_wr_i.sel == SEL_DAC_SHARED) begin
        shared_high_neg_dac_q <= reg_wr_i.data[11:0];
      end
      if (ofs_wr_i) begin
        data_ram_offset_q <= ofs_value_i;
      end
      if (exchange_route_wr_i) begin
        exchange_route_q <= exchange_route_i;
      end
    end
  end

  // a received word overrides a same-cycle core write
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      backdoor_data_q <= RESET_WORD;
    end else if (backdoor_rx_valid_i) begin
      backdoor_data_q <= backdoor_rx_i;
    end else if (wr_en && reg_wr_i.sel == SEL_BD_DATA) begin
      backdoor_data_q <= reg_wr_i.data;
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      core_exchange_word_q <= RESET_WORD;
    end else if (wr_en && reg_wr_i.sel == SEL_EXCHANGE) begin
      core_exchange_word_q <= reg_wr_i.data;
    end else begin
      core_exchange_word_q <= exchange_in_i;
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      interrupt_status_mirror_q <= RESET_WORD;
      ram_addr_q <= 6'h00;
    end else begin
      interrupt_status_mirror_q <= core_id_i ? core1_interrupt_flags_i
                                             : core0_interrupt_flags_i;
      ram_addr_q <= ofs_sel_i ? (ram_addr_i + data_ram_offset_q) &
                                RAM_ADDR_MASK : ram_addr_i;
    end
  end

  genvar gj;
  generate
    for (gj = 0; gj < 4; gj++) begin : g_dac
      always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
          dac_rel_q[gj] <= 14'h0000;
        end else if (wr_en && reg_wr_i.sel == SEL_DAC_OO + 5'(gj)) begin
          dac_rel_q[gj] <= reg_wr_i.data[13:0];
        end
      end
      always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
          dac_phys_q[gj] <= 14'h0000;
        end else begin
          dac_phys_q[gj] <= dac_rel_q[dac_map(core_id_i, channel_id_i,
                                              2'(gj))];
        end
      end
    end
  endgenerate

  // alu datapath
  always_comb begin
    op_a = gen_q[alu_cmd_i.src_a];
    op_b = gen_q[alu_cmd_i.src_b];
    if (alu_cmd_i.op == OP_SUB) begin
      sum_ext = {1'b0, op_a} - {1'b0, op_b};
      uns_under = sum_ext[16];
      uns_over = 1'b0;
      sgn_over = !op_a[15] && op_b[15] && sum_ext[15];
      sgn_under = op_a[15] && !op_b[15] && !sum_ext[15];
    end else begin
      sum_ext = {1'b0, op_a} + {1'b0, op_b};
      uns_under = 1'b0;
      uns_over = sum_ext[16];
      sgn_over = !op_a[15] && !op_b[15] && sum_ext[15];
      sgn_under = op_a[15] && op_b[15] && !sum_ext[15];
    end
    carry = sum_ext[16];
    sum_wrap = sum_ext[15:0];
    case (cond_q[B_LIMIT_HI:B_LIMIT_LO])
      LIMIT_SIGNED: sum_out = sgn_over ? SAT_SMAX :
                              sgn_under ? SAT_SMIN : sum_wrap;
      LIMIT_UNSIGNED: sum_out = uns_over ? SAT_UMAX :
                                uns_under ? SAT_UMIN : sum_wrap;
      default: sum_out = sum_wrap;
    endcase
    case (alu_cmd_i.op)
      OP_AND: mask_res = op_a & gen_q[5];
      OP_OR: mask_res = op_a | gen_q[5];
      OP_XOR: mask_res = op_a ^ gen_q[5];
      default: mask_res = ~gen_q[5];
    endcase
    pair = {gen_q[6], gen_q[7]};
    if (alu_cmd_i.op == OP_SHL32) begin
      pair_sh = {pair[30:0], 1'b0};
      shift_bit = pair[31];
      one_sh = {op_a[14:0], 1'b0};
    end else if (alu_cmd_i.op == OP_SHR32) begin
      pair_sh = {1'b0, pair[31:1]};
      shift_bit = pair[0];
      one_sh = {1'b0, op_a[15:1]};
    end else if (alu_cmd_i.op == OP_SHL) begin
      pair_sh = pair;
      shift_bit = op_a[15];
      one_sh = {op_a[14:0], 1'b0};
    end else begin
      pair_sh = pair;
      shift_bit = op_a[0];
      one_sh = {1'b0, op_a[15:1]};
    end
  end

  // multiply runs one bit per cycle; other ops finish at once
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      state_q <= ST_IDLE;
      mul_cnt_q <= 5'h00;
      mul_acc_q <= 32'h0000_0000;
      mul_mcand_q <= RESET_WORD;
      mul_mplier_q <= RESET_WORD;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (alu_go && alu_cmd_i.op == OP_MUL) begin
            state_q <= ST_MUL;
            mul_cnt_q <= MUL_CYCLES;
            mul_acc_q <= 32'h0000_0000;
            mul_mcand_q <= op_a;
            mul_mplier_q <= op_b;
          end
        end
        ST_MUL: begin
          mul_acc_q <= {mul_acc_q[30:0], 1'b0} +
                       (mul_mplier_q[15] ? {16'h0000, mul_mcand_q}
                                         : 32'h0000_0000);
          mul_mplier_q <= {mul_mplier_q[14:0], 1'b0};
          mul_cnt_q <= mul_cnt_q - 5'h01;
          if (mul_cnt_q == 5'h01) begin
            state_q <= ST_IDLE;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  logic [31:0] mul_final;
  assign mul_final = {mul_acc_q[30:0], 1'b0} +
                     (mul_mplier_q[15] ? {16'h0000, mul_mcand_q}
                                       : 32'h0000_0000);
  logic mul_end;
  assign mul_end = (state_q == ST_MUL) && (mul_cnt_q == 5'h01);

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      for (int i = 0; i < 8; i++) begin
        gen_q[i] <= RESET_WORD;
      end
    end else if (mul_end) begin
      gen_q[6] <= mul_final[31:16];
      gen_q[7] <= mul_final[15:0];
    end else if (alu_go) begin
      case (alu_cmd_i.op)
        OP_ADD, OP_SUB: gen_q[alu_cmd_i.dst] <= sum_out;
        OP_AND, OP_OR, OP_XOR, OP_NOT: gen_q[alu_cmd_i.dst] <= mask_res;
        OP_SHL, OP_SHR: gen_q[alu_cmd_i.dst] <= one_sh;
        OP_SHL32, OP_SHR32: begin
          gen_q[6] <= pair_sh[31:16];
          gen_q[7] <= pair_sh[15:0];
        end
        OP_TOINT, OP_TOINT_RST: gen_q[alu_cmd_i.dst] <=
          op_a[15] ? 16'(-op_a) : op_a;
        default: ;
      endcase
    end else if (wr_en && reg_wr_i.sel[4:3] == SEL_GEN0[4:3]) begin
      gen_q[reg_wr_i.sel[2:0]] <= reg_wr_i.data;
    end
  end

  // condition word; each class touches only its own flags, except the 32-bit shifts, which also set the product flags
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      cond_q <= 16'h0001;
    end else begin
      cond_q[B_OP_DONE] <= !(alu_go && alu_cmd_i.op == OP_MUL) &&
                           !(state_q == ST_MUL && !mul_end);
      if (wr_en && reg_wr_i.sel == SEL_COND) begin
        cond_q[15:1] <= reg_wr_i.data[15:1];
      end
      if (mul_end) begin
        cond_q[B_PROD_HI_NZ] <= |mul_final[31:16];
        cond_q[B_PROD_LO_NZ] <= |mul_final[15:0];
      end else if (alu_go) begin
        case (alu_cmd_i.op)
          OP_ADD, OP_SUB: begin
            cond_q[B_CARRY] <= carry;
            cond_q[B_SUM_ZERO] <= sum_out == 16'h0000;
            cond_q[B_SUM_NEG] <= sum_out[15];
            cond_q[B_UNS_UNDER] <= uns_under;
            cond_q[B_UNS_OVER] <= uns_over;
            cond_q[B_SGN_UNDER] <= sgn_under;
            cond_q[B_SGN_OVER] <= sgn_over;
          end
          OP_AND, OP_OR, OP_XOR, OP_NOT: begin
            cond_q[B_MASK_ZERO] <= mask_res == 16'h0000;
            cond_q[B_MASK_ONES] <= mask_res == 16'hFFFF;
          end
          OP_SHL, OP_SHR: cond_q[B_SHIFT_OUT] <= shift_bit;
          OP_SHL32, OP_SHR32: begin
            cond_q[B_SHIFT_OUT] <= shift_bit;
            cond_q[B_PROD_HI_NZ] <= |pair_sh[31:16];
            cond_q[B_PROD_LO_NZ] <= |pair_sh[15:0];
          end
          OP_TOINT:
            cond_q[B_SIGN_ACC] <= cond_q[B_SIGN_ACC] ^ op_a[15];
          OP_TOINT_RST: cond_q[B_SIGN_ACC] <= op_a[15];
          default: ;
        endcase
      end
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      rd_data_q <= RESET_WORD;
    end else begin
      case (rd_sel_i)
        SEL_HOST_CTRL: rd_data_q <= host_control_word_q;
        SEL_OUT_WORD: rd_data_q <= core_output_word_q;
        SEL_BD_DATA: rd_data_q <= backdoor_data_q;
        SEL_DAC_OO: rd_data_q <= {2'h0, dac_rel_q[0]};
        SEL_DAC_PO: rd_data_q <= {2'h0, dac_rel_q[1]};
        SEL_DAC_OP: rd_data_q <= {2'h0, dac_rel_q[2]};
        SEL_DAC_PP: rd_data_q <= {2'h0, dac_rel_q[3]};
        SEL_DAC_SHARED: rd_data_q <= {4'h0, shared_high_neg_dac_q};
        SEL_BD_ADDR: rd_data_q <= {8'h00, backdoor_address_q};
        SEL_IRQ_MIRROR: rd_data_q <= interrupt_status_mirror_q;
        SEL_EXCHANGE: rd_data_q <= core_exchange_word_q;
        SEL_RAM_OFS: rd_data_q <= {10'h000, data_ram_offset_q};
        SEL_COND: rd_data_q <= cond_q;
        default: rd_data_q <= rd_sel_i[4:3] == SEL_GEN0[4:3] ?
                              gen_q[rd_sel_i[2:0]] : RESET_WORD;
      endcase
    end
  end

  assign host_control_o = host_control_word_q;
  assign core_output_o = core_output_word_q;
  assign rd_data_o = rd_data_q;
  assign backdoor_data_o = backdoor_data_q;
  assign backdoor_address_o = backdoor_address_q;
  assign current_dac_a_o = dac_phys_q[0];
  assign current_dac_b_o = dac_phys_q[1];
  assign current_dac_c_o = dac_phys_q[2];
  assign current_dac_d_o = dac_phys_q[3];
  assign shared_high_neg_dac_o = shared_high_neg_dac_q;
  assign exchange_out_o = core_exchange_word_q;
  assign exchange_route_o = exchange_route_q;
  assign ram_addr_o = ram_addr_q;
  assign alu_condition_o = cond_q;

  a_busy_ignores: assert property (@(posedge clk_i) disable iff (reset_i)
    !cond_q[B_OP_DONE] && !(wr_en && reg_wr_i.sel == SEL_GEN0)
    |=> $stable(gen_q[0]))
    else $error("request taken while busy");
  a_mul_busy_len: assert property (@(posedge clk_i) disable iff (reset_i)
    $rose(state_q == ST_MUL) |-> !cond_q[B_OP_DONE] [*8])
    else $error("done flag rose early");
  a_mirror_track: assert property (@(posedge clk_i) disable iff (reset_i)
    !reset_i && !core_id_i |=> interrupt_status_mirror_q ==
    $past(core0_interrupt_flags_i))
    else $error("mirror lost track");
  a_low_byte_ro: assert property (@(posedge clk_i) disable iff (reset_i)
    !host_wr_i |=> $stable(host_control_word_q[7:0]))
    else $error("low byte changed without host");
  a_sat_signed: assert property (@(posedge clk_i) disable iff (reset_i)
    alu_go && !mul_end && cond_q[B_LIMIT_HI:B_LIMIT_LO] == LIMIT_SIGNED &&
    (alu_cmd_i.op == OP_ADD || alu_cmd_i.op == OP_SUB) &&
    (sgn_over || sgn_under)
    |=> gen_q[$past(alu_cmd_i.dst)] ==
    ($past(sgn_over) ? SAT_SMAX : SAT_SMIN) &&
    cond_q[B_SGN_OVER] == $past(sgn_over))
    else $error("signed saturation missing");
  a_carry_flag: assert property (@(posedge clk_i) disable iff (reset_i)
    alu_go && alu_cmd_i.op == OP_ADD && !mul_end
    |=> cond_q[B_CARRY] ==
    $past({1'b0, op_a} + {1'b0, op_b} > 17'h0FFFF))
    else $error("carry flag wrong");
  a_mask_keep: assert property (@(posedge clk_i) disable iff (reset_i)
    alu_go && alu_cmd_i.op == OP_ADD && !mul_end &&
    !(wr_en && reg_wr_i.sel == SEL_COND)
    |=> $stable(cond_q[B_MASK_ZERO]))
    else $error("mask flag disturbed");
  a_ofs_add: assert property (@(posedge clk_i) disable iff (reset_i)
    ofs_sel_i |=> ram_addr_q ==
    6'($past(ram_addr_i) + $past(data_ram_offset_q)))
    else $error("offset not applied");
endmodule
`default_nettype wire

// [testbench/host_model.sv]
// host model: writes the shared control word
`default_nettype none
module host_model (
  input wire logic clk_i,
  output logic wr_o,
  output logic [15:0] wdata_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    wr_o = 1'b0;
    wdata_o = 16'h0000;
  end
  // host has no write path to the output word, it only reads it
  task automatic write(input logic [15:0] d);
    @(posedge clk_i);
    wr_o <= 1'b1;
    wdata_o <= d;
    @(posedge clk_i);
    wr_o <= 1'b0;
    // released data shows the inverse, never the stale word
    wdata_o <= ~d;
  endtask
endmodule
`default_nettype wire

// [testbench/microcore_regs_alu_flags_tb_top.sv]
// bench for the core register set, DAC routing and ALU flags
`default_nettype none
module microcore_regs_alu_flags_tb_top
  import core_regs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 1'b0, reset_i = 1'b1, core_id = 1'b0, ch_id = 1'b0;
  logic split = 1'b0, bset = 1'b0, bval = 1'b0, rxv = 1'b0;
  logic ofs_wr = 1'b0, ofs_sel = 1'b0, alu_req = 1'b0, rt_wr = 1'b0;
  logic [2:0] bidx = 3'h0;
  logic [1:0] rt = 2'h0, rto;
  logic [5:0] ofs_v = 6'h00, raddr = 6'h00, rao;
  logic [15:0] f0 = 16'h0000, f1 = 16'h0000, xin = 16'h0000;
  logic [15:0] rx = 16'h0000, hc, co, rdd, bdd, xo, cond, hwd, rv;
  logic [4:0] rd_sel = 5'h00;
  reg_wr_s rw = '0;
  alu_req_s cmd = '0;
  logic [7:0] bda;
  logic [3:0][13:0] dac;
  logic [11:0] shd;
  logic hwr;
  int fail_count = 0, comparisons = 0, seed = 67, cyc = 0;
  always #25 clk_i = ~clk_i;
  host_model host_model_inst (.clk_i(clk_i), .wr_o(hwr), .wdata_o(hwd));
  core_regs_alu core_regs_alu_inst (.clk_i(clk_i), .reset_i(reset_i),
    .core_id_i(core_id), .channel_id_i(ch_id), .split_status_i(split),
    .host_wr_i(hwr), .host_wdata_i(hwd), .core0_interrupt_flags_i(f0),
    .core1_interrupt_flags_i(f1), .exchange_in_i(xin),
    .exchange_route_i(rt), .exchange_route_wr_i(rt_wr), .bit_set_i(bset),
    .bit_index_i(bidx), .bit_value_i(bval), .backdoor_rx_i(rx),
    .backdoor_rx_valid_i(rxv), .ofs_wr_i(ofs_wr), .ofs_value_i(ofs_v),
    .ram_addr_i(raddr), .ofs_sel_i(ofs_sel), .reg_wr_i(rw),
    .rd_sel_i(rd_sel), .alu_req_i(alu_req), .alu_cmd_i(cmd),
    .host_control_o(hc), .core_output_o(co), .rd_data_o(rdd),
    .backdoor_data_o(bdd), .backdoor_address_o(bda),
    .current_dac_a_o(dac[0]), .current_dac_b_o(dac[1]),
    .current_dac_c_o(dac[2]), .current_dac_d_o(dac[3]),
    .shared_high_neg_dac_o(shd), .exchange_out_o(xo),
    .exchange_route_o(rto), .ram_addr_o(rao), .alu_condition_o(cond));
  task automatic chk(input string n, input logic [15:0] e,
                     input logic [15:0] g);
    comparisons++;
    if (g !== e) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic wr(input logic [4:0] s, input logic [15:0] d);
    @(posedge clk_i);
    rw <= '{1'b1, s, d};
    @(posedge clk_i);
    rw.wr <= 1'b0;
    @(negedge clk_i);
  endtask
  task automatic rd(input logic [4:0] s);
    @(posedge clk_i);
    rd_sel <= s;
    @(posedge clk_i);
    @(negedge clk_i);
    rv = rdd;
  endtask
  task automatic alu(input alu_op_e op, input logic [2:0] d, a, b);
    @(posedge clk_i);
    alu_req <= 1'b1;
    cmd <= '{op, d, a, b};
    @(posedge clk_i);
    alu_req <= 1'b0;
    @(negedge clk_i);
  endtask
  // result, zero, negative, uu, uo, su, so, carry
  function automatic logic [22:0] arith(input logic [1:0] m, input logic s,
                                        input logic [15:0] a, b);
    logic [16:0] r;
    logic so, su;
    logic [15:0] v;
    r = s ? {1'b0, a} - {1'b0, b} : {1'b0, a} + {1'b0, b};
    so = !a[15] && (s ? b[15] : !b[15]) && r[15];
    su = a[15] && (s ? !b[15] : b[15]) && !r[15];
    v = r[15:0];
    if (m == LIMIT_SIGNED)
      v = so ? SAT_SMAX : (su ? SAT_SMIN : v);
    if (m == LIMIT_UNSIGNED)
      v = (r[16] && !s) ? SAT_UMAX : ((r[16] && s) ? SAT_UMIN : v);
    return {v, v == 16'h0000, v[15], s && r[16], !s && r[16], su, so, r[16]};
  endfunction
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      fail_count++;
      test_done();
    end
  end
  initial begin
    logic [15:0] w, a, b;
    logic [15:0] ca [4];
    logic [13:0] dv [4];
    logic [1:0] pmap [4][4];
    logic [22:0] e;
    logic [31:0] p;
    logic [1:0] m;
    logic s;
    int n;
    ca = '{16'h7FFF, 16'h8000, 16'hFFFF, 16'h0000};
    // physical DAC per core/channel row, relative slot column
    pmap = '{'{2'h0, 2'h1, 2'h2, 2'h3}, '{2'h1, 2'h0, 2'h3, 2'h2},
             '{2'h2, 2'h3, 2'h0, 2'h1}, '{2'h3, 2'h2, 2'h1, 2'h0}};
    f0 = 16'($random(seed));
    f1 = 16'($random(seed));
    xin = 16'($random(seed));
    repeat (16) @(posedge clk_i);
    reset_i <= 1'b0;
    @(negedge clk_i);
    chk("cond reset", 16'h0001, cond);
    w = 16'($random(seed));
    host_model_inst.write(w);
    @(negedge clk_i);
    chk("host word", w, hc);
    split <= 1'b1;
    a = 16'($random(seed));
    host_model_inst.write(a);
    @(negedge clk_i);
    w = {w[15:8], a[7:0]};
    chk("split word", w, hc);
    @(posedge clk_i);
    bset <= 1'b1;
    bidx <= 3'h3;
    bval <= ~w[11];
    @(posedge clk_i);
    bset <= 1'b0;
    w[11] = ~w[11];
    rd(SEL_HOST_CTRL);
    chk("bit write", w, rv);
    a = 16'($random(seed));
    wr(SEL_OUT_WORD, a);
    chk("out word", a, co);
    wr(SEL_BD_DATA, ~a);
    chk("bd data", ~a, bdd);
    @(posedge clk_i);
    rx <= a;
    rxv <= 1'b1;
    @(posedge clk_i);
    rxv <= 1'b0;
    rx <= ~a;
    @(negedge clk_i);
    chk("bd rx", a, bdd);
    wr(SEL_BD_ADDR, a);
    chk("bd addr", {8'h00, a[7:0]}, {8'h00, bda});
    wr(SEL_DAC_SHARED, a);
    chk("shared dac", {4'h0, a[11:0]}, {4'h0, shd});
    for (int c = 0; c < 4; c++) begin
      @(posedge clk_i);
      core_id <= c[0];
      ch_id <= c[1];
      for (int k = 0; k < 4; k++) begin
        dv[k] = 14'($random(seed));
        wr(SEL_DAC_OO + 5'(k), {2'h0, dv[k]});
      end
      // routed copy lags the relative register by one cycle
      @(negedge clk_i);
      for (int k = 0; k < 4; k++)
        chk("dac map", {2'h0, dv[k]}, {2'h0, dac[pmap[c][k]]});
      rd(SEL_IRQ_MIRROR);
      chk("irq mirror", c[0] ? f1 : f0, rv);
      @(posedge clk_i);
      f0 <= ~f0;
      f1 <= f1 + 16'h0001;
    end
    rd(SEL_EXCHANGE);
    chk("exchange", xin, rv);
    wr(SEL_EXCHANGE, ~xin);
    chk("exchange out", ~xin, xo);
    @(negedge clk_i);
    chk("exchange back", xin, xo);
    @(posedge clk_i);
    rt <= 2'($random(seed));
    rt_wr <= 1'b1;
    @(posedge clk_i);
    rt_wr <= 1'b0;
    @(negedge clk_i);
    chk("route", {14'h0, rt}, {14'h0, rto});
    for (int k = 0; k < 4; k++) begin
      @(posedge clk_i);
      ofs_wr <= 1'b1;
      ofs_v <= 6'($random(seed));
      @(posedge clk_i);
      ofs_wr <= 1'b0;
      raddr <= 6'($random(seed));
      ofs_sel <= k[0];
      @(posedge clk_i);
      @(negedge clk_i);
      chk("ram addr", {10'h0, k[0] ? raddr + ofs_v : raddr},
          {10'h0, rao});
    end
    for (int i = 0; i < 24; i++) begin
      m = i[1:0];
      s = i[0] ^ i[2];
      a = i < 4 ? ca[i] : 16'($random(seed));
      b = i < 4 ? 16'h0001 : 16'($random(seed));
      wr(SEL_COND, {3'h0, m, 11'h000});
      wr(SEL_GEN0 + 5'h01, a);
      wr(SEL_GEN0 + 5'h02, b);
      alu(s ? OP_SUB : OP_ADD, 3'h3, 3'h1, 3'h2);
      e = arith(m, s, a, b);
      chk("limit", {14'h0, m}, {14'h0, cond[12:11]});
      if (!m[0])
        chk("flags", {10'h0, e[6:1]}, {10'h0, cond[6:1]});
      if (!s)
        chk("carry", 16'(e[0]), 16'(cond[B_CARRY]));
      rd(SEL_GEN0 + 5'h03);
      chk("sum", e[22:7], rv);
    end
    wr(SEL_GEN0 + 5'h01, 16'hFFFF);
    for (int k = 0; k < 4; k++) begin
      wr(SEL_MASK_SRC, k == 0 ? 16'h0000 : 16'hFFFF);
      alu(alu_op_e'(OP_AND + 4'(k)), 3'h0, 3'h1, 3'h5);
      chk("mask flags", k == 1 ? 16'h0001 : 16'h0002,
          {14'h0, cond[10:9]});
    end
    for (int k = 0; k < 2; k++) begin
      wr(SEL_GEN0 + 5'h01, 16'h8000);
      alu(k ? OP_SHR : OP_SHL, 3'h0, 3'h1, 3'h1);
      chk("shift out", 16'(!k), 16'(cond[B_SHIFT_OUT]));
      rd(SEL_GEN0);
      chk("shift", k ? 16'h4000 : 16'h0000, rv);
    end
    for (int k = 0; k < 5; k++) begin
      wr(SEL_GEN0 + 5'h01, k[1] ? 16'h0005 : 16'h8000);
      alu(k[0] ? OP_TOINT : OP_TOINT_RST, 3'h0, 3'h1, 3'h1);
      chk("sign acc", 16'(k == 0 || k == 4), 16'(cond[B_SIGN_ACC]));
    end
    a = 16'($random(seed));
    b = 16'($random(seed));
    wr(SEL_GEN0 + 5'h01, a);
    wr(SEL_GEN0 + 5'h02, b);
    wr(SEL_GEN0, 16'h1234);
    w = cond;
    alu(OP_MUL, 3'h6, 3'h1, 3'h2);
    chk("busy", 16'h0000, 16'(cond[B_OP_DONE]));
    alu(OP_ADD, 3'h0, 3'h1, 3'h2);
    n = 0;
    while (cond[B_OP_DONE] !== 1'b1 && n < 40) begin
      @(negedge clk_i);
      n++;
    end
    chk("done", 16'h0001, 16'(cond[B_OP_DONE]));
    p = a * b;
    chk("prod flags", {14'h0, |p[31:16], |p[15:0]},
        {14'h0, cond[8:7]});
    chk("kept flags", {14'h0, w[10:9]}, {14'h0, cond[10:9]});
    rd(SEL_PROD_HIGH);
    chk("prod high", p[31:16], rv);
    rd(SEL_PROD_LOW);
    chk("prod low", p[15:0], rv);
    rd(SEL_GEN0);
    chk("busy drop", 16'h1234, rv);
    test_done();
  end
endmodule
`default_nettype wire
